// ===== rtl/orl_ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
module orl_ms_timer
  import orl_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // control
  input  wire logic                  load_i,
  input  wire logic [ORL_TIME_W-1:0] load_val_i,
  input  wire logic                  tick_i,
  // status
  output logic                       done_o
);

  typedef struct packed {
    logic [ORL_TIME_W-1:0] cnt;
    logic                  skip;
  } orl_tmr_state_s;

  orl_tmr_state_s st_q;
  orl_tmr_state_s st_d;

  // load wins over counting so a held load keeps the timer armed
  // first tick after a load is a partial period, so it is not counted
  always_comb begin
    st_d = st_q;
    if (load_i) begin
      st_d.cnt  = load_val_i;
      st_d.skip = (load_val_i != ORL_RST_TIME);
    end else if (tick_i && st_q.skip) begin
      st_d.skip = 1'b0;
    end else if (tick_i && (st_q.cnt != ORL_RST_TIME)) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.cnt  <= ORL_RST_TIME;
      st_q.skip <= ORL_RST_LEVEL;
    end else begin
      st_q <= st_d;
    end
  end

  // not gated by load_i: a caller may feed done_o back into load_i
  assign done_o = (st_q.cnt == ORL_RST_TIME);

endmodule
`default_nettype wire

// ===== rtl/orl_pkg.sv
package orl_pkg;

  // trigger slots per relay and width of a signal selector
  localparam int unsigned ORL_NUM_TRIG = 7;
  localparam int unsigned ORL_SEL_W    = 8;
  localparam int unsigned ORL_TIME_W   = 16;

  // time base: hold and off-delay settings count in milliseconds
  localparam int unsigned ORL_CLK_PERIOD_NS = 10;
  localparam int unsigned ORL_TICK_NS       = 1000000;
  localparam int unsigned ORL_TICK_CYCLES   = ORL_TICK_NS / ORL_CLK_PERIOD_NS;
  localparam int unsigned ORL_DIV_W         = 24;

  // reset values
  localparam logic ORL_RST_LEVEL = 1'b0;
  localparam logic [ORL_TIME_W-1:0] ORL_RST_TIME = '0;
  localparam logic [ORL_DIV_W-1:0]  ORL_RST_DIV  = '0;

  typedef enum logic {
    ORL_WORKING_CURRENT,
    ORL_CLOSED_CIRCUIT
  } orl_mode_e;

  typedef struct packed {
    logic                 assigned;
    logic [ORL_SEL_W-1:0] sel;
    logic                 invert;
  } orl_slot_s;

  typedef struct packed {
    orl_slot_s [ORL_NUM_TRIG-1:0] slot;
    logic                         relay_invert;
    logic                         latched;
    logic                         ack_assigned;
    logic [ORL_SEL_W-1:0]         ack_sel;
    logic [ORL_TIME_W-1:0]        hold_ms;
    logic [ORL_TIME_W-1:0]        off_delay_ms;
    orl_mode_e                    mode;
  } orl_relay_cfg_s;

  typedef struct packed {
    logic panel;
    logic scada_all;
    logic all_outputs_ack_signal;
    logic remote_reset_en;
  } orl_ack_s;

endpackage

// ===== rtl/orl_relay_top.sv
// Overview of operation
// - relay state is OR of seven triggers
// - per-trigger inversion; unassigned slot reads zero
// - relay-level inversion inverts the OR result
// - no assignments forces zero, ignores inversion
// - unlatched contact follows trigger state directly
// - latched state stored until acknowledged
// - clear latch only after triggers drop
// - acknowledge waits for off-delay retention time
// - each change held for minimum hold time
// - latched states survive RESTART_I, RST_I clears them
// - own ack signal only when latched, per relay
// - group and link ack need remote enable
// - working-current or closed-circuit contact drive
// - life contact energised only after clean boot
`timescale 1ns/10ps
`default_nettype none
module orl_relay_top
  import orl_pkg::*;
#(
  parameter int unsigned NUM_RELAYS  = 8,
  parameter int unsigned NUM_SIGNALS = 256,
  parameter int unsigned TICK_CYCLES = ORL_TICK_CYCLES
)(
  // clock and reset
  input  wire logic                           SYS_CLK_I,
  input  wire logic                           RST_I,
  // device restart and health
  input  wire logic                           RESTART_I,
  input  wire logic                           BOOT_DONE_I,
  input  wire logic                           INT_FAULT_I,
  // internal protection signals
  input  wire logic [NUM_SIGNALS-1:0]         SIGNALS_I,
  // configuration
  input  wire orl_relay_cfg_s [NUM_RELAYS-1:0] RELAY_CFG_I,
  // acknowledgement sources
  input  wire orl_ack_s                       ACK_I,
  // relay contacts and status
  output logic [NUM_RELAYS-1:0]               CONTACT_O,
  output logic [NUM_RELAYS-1:0]               RELAY_STATE_O,
  output logic [NUM_RELAYS-1:0]               LATCH_HELD_O,
  output logic                                LIFE_CONTACT_O
);

  // top-level state: millisecond divider and life contact
  typedef struct packed {
    logic [ORL_DIV_W-1:0] div;
    logic                 tick;
    logic                 life;
  } orl_top_state_s;

  // per-relay state
  typedef struct packed {
    logic latch;
    logic out;
    logic contact;
  } orl_rly_state_s;

  localparam logic [ORL_DIV_W-1:0] DIV_LAST = ORL_DIV_W'(TICK_CYCLES - 1);

  orl_top_state_s top_q;
  orl_top_state_s top_d;

  // an all-relay acknowledge; remote sources gated by the enable
  logic ack_all;

  always_comb begin
    ack_all = ACK_I.panel
            | (ACK_I.remote_reset_en & (ACK_I.scada_all | ACK_I.all_outputs_ack_signal));
  end

  always_comb begin
    top_d = top_q;
    top_d.tick = 1'b0;
    if (top_q.div == DIV_LAST) begin
      top_d.div  = ORL_RST_DIV;
      top_d.tick = 1'b1;
    end else begin
      top_d.div = top_q.div + 1'b1;
    end
    // released through boot and any restart, picks up when healthy
    top_d.life = BOOT_DONE_I & ~INT_FAULT_I & ~RESTART_I;
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      top_q.div  <= ORL_RST_DIV;
      top_q.tick <= ORL_RST_LEVEL;
      top_q.life <= ORL_RST_LEVEL;
    end else begin
      top_q <= top_d;
    end
  end

  assign LIFE_CONTACT_O = top_q.life;

  genvar r;
  generate
    for (r = 0; r < NUM_RELAYS; r++) begin : g_relay
      orl_rly_state_s st_q;
      orl_rly_state_s st_d;
      orl_relay_cfg_s cfg;
      logic [ORL_NUM_TRIG-1:0] trig;
      logic any_assigned;
      logic coll;
      logic logic_state;
      logic ack_here;
      logic hold_done;
      logic off_done;
      logic change;

      assign cfg = RELAY_CFG_I[r];

      always_comb begin
        for (int k = 0; k < ORL_NUM_TRIG; k++) begin
          // unassigned slot stays zero whatever its inversion
          trig[k] = cfg.slot[k].assigned
                  & (SIGNALS_I[cfg.slot[k].sel] ^ cfg.slot[k].invert);
        end
        any_assigned = 1'b0;
        for (int k = 0; k < ORL_NUM_TRIG; k++) begin
          any_assigned = any_assigned | cfg.slot[k].assigned;
        end
      end

      always_comb begin
        coll = 1'b0;
        if (any_assigned) begin
          coll = (|trig) ^ cfg.relay_invert;
        end
      end

      // own ack signal only counts while latching is on
      always_comb begin
        ack_here = ack_all
                 | (cfg.latched & cfg.ack_assigned & SIGNALS_I[cfg.ack_sel]);
      end

      // retention timer rearmed while the trigger state coll is set, not while a latch alone drives the relay
      orl_ms_timer u_off_delay (
        .clk_i      (SYS_CLK_I),
        .rst_i      (RST_I),
        .load_i     (coll),
        .load_val_i (cfg.off_delay_ms),
        .tick_i     (top_q.tick),
        .done_o     (off_done)
      );

      always_comb begin
        logic_state = cfg.latched ? (st_q.latch | coll) : coll;
        change      = (logic_state != st_q.out);
      end

      // hold timer restarts on every output change
      orl_ms_timer u_hold (
        .clk_i      (SYS_CLK_I),
        .rst_i      (RST_I),
        .load_i     (change & hold_done),
        .load_val_i (cfg.hold_ms),
        .tick_i     (top_q.tick),
        .done_o     (hold_done)
      );

      always_comb begin
        st_d = st_q;
        // latch is untouched by RESTART_I so it comes back as it was
        if (!cfg.latched || !any_assigned) begin
          st_d.latch = 1'b0;
        end else if (coll) begin
          st_d.latch = 1'b1;
        end else if (ack_here && off_done) begin
          st_d.latch = 1'b0;
        end
        if (change && hold_done) begin
          st_d.out = logic_state;
        end
        // closed-circuit keeps the coil energised at rest
        if (cfg.mode == ORL_CLOSED_CIRCUIT) begin
          st_d.contact = ~st_d.out;
        end else begin
          st_d.contact = st_d.out;
        end
      end

      always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          st_q.latch   <= ORL_RST_LEVEL;
          st_q.out     <= ORL_RST_LEVEL;
          st_q.contact <= ORL_RST_LEVEL;
        end else begin
          st_q <= st_d;
        end
      end

      assign CONTACT_O[r]     = st_q.contact;
      assign RELAY_STATE_O[r] = st_q.out;
      assign LATCH_HELD_O[r]  = st_q.latch;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== test/orl_relay_properties.sv
`timescale 1ns/10ps
`default_nettype none
module orl_relay_properties
  import orl_pkg::*;
#(
  parameter int unsigned NUM_RELAYS  = 8,
  parameter int unsigned NUM_SIGNALS = 256,
  parameter int unsigned TICK_CYCLES = ORL_TICK_CYCLES
)(
  input wire logic                            SYS_CLK_I,
  input wire logic                            RST_I,
  input wire logic                            RESTART_I,
  input wire logic                            BOOT_DONE_I,
  input wire logic                            INT_FAULT_I,
  input wire logic [NUM_SIGNALS-1:0]          SIGNALS_I,
  input wire orl_relay_cfg_s [NUM_RELAYS-1:0] RELAY_CFG_I,
  input wire orl_ack_s                        ACK_I,
  input wire logic [NUM_RELAYS-1:0]           CONTACT_O,
  input wire logic [NUM_RELAYS-1:0]           RELAY_STATE_O,
  input wire logic [NUM_RELAYS-1:0]           LATCH_HELD_O,
  input wire logic                            LIFE_CONTACT_O
);
  orl_relay_cfg_s c0;
  logic           coll0;
  logic           asg0;
  logic           ack0;
  assign c0 = RELAY_CFG_I[0];
  always_comb begin
    coll0 = 1'b0;
    asg0  = 1'b0;
    for (int k = 0; k < ORL_NUM_TRIG; k++) begin
      asg0  = asg0 | c0.slot[k].assigned;
      coll0 = coll0 | (c0.slot[k].assigned & (SIGNALS_I[c0.slot[k].sel] ^ c0.slot[k].invert));
    end
    coll0 = asg0 & (coll0 ^ c0.relay_invert);
    ack0  = ACK_I.panel | (ACK_I.remote_reset_en & (ACK_I.scada_all | ACK_I.all_outputs_ack_signal))
          | (c0.ack_assigned & SIGNALS_I[c0.ack_sel]);
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  a_life_boot: assert property (!BOOT_DONE_I |=> !LIFE_CONTACT_O) else $error("life contact early");
  a_life_fault: assert property (INT_FAULT_I || RESTART_I |=> !LIFE_CONTACT_O) else $error("life on fault");
  a_life_up: assert property (BOOT_DONE_I && !INT_FAULT_I && !RESTART_I |=> LIFE_CONTACT_O) else $error("life off");
  a_contact_mode: assert property (!$past(RST_I) && $stable(c0.mode) |-> CONTACT_O[0] == (RELAY_STATE_O[0] ^ (c0.mode == ORL_CLOSED_CIRCUIT))) else $error("contact polarity");
  a_latch_set: assert property (c0.latched && coll0 |=> LATCH_HELD_O[0]) else $error("latch not set");
  a_latch_keep: assert property (LATCH_HELD_O[0] && c0.latched && asg0 && !ack0 |=> LATCH_HELD_O[0]) else $error("latch lost");
  a_clear_trig_high: assert property (LATCH_HELD_O[0] && c0.latched && coll0 |=> LATCH_HELD_O[0]) else $error("cleared early");
  a_unlatch_clear: assert property (!c0.latched || !asg0 |=> !LATCH_HELD_O[0]) else $error("latch stuck");
  c_latch: cover property (LATCH_HELD_O[0] ##1 !LATCH_HELD_O[0]);
  c_closed: cover property (c0.mode == ORL_CLOSED_CIRCUIT && CONTACT_O[0]);
  c_life: cover property ($rose(LIFE_CONTACT_O));
endmodule
bind orl_relay_top orl_relay_properties #(.NUM_RELAYS(NUM_RELAYS), .NUM_SIGNALS(NUM_SIGNALS),
  .TICK_CYCLES(TICK_CYCLES)) u_orl_relay_properties (.SYS_CLK_I, .RST_I, .RESTART_I, .BOOT_DONE_I,
  .INT_FAULT_I, .SIGNALS_I, .RELAY_CFG_I, .ACK_I, .CONTACT_O, .RELAY_STATE_O, .LATCH_HELD_O,
  .LIFE_CONTACT_O);
`default_nettype wire

// ===== test/orl_switchgear.sv
`timescale 1ns/10ps
`default_nettype none
module orl_switchgear (
  // clock and coil
  input  wire logic clk_i,
  input  wire logic coil_i,
  // breaker view
  output logic      closed_o
);
  // auxiliary contact lags the coil by one clock
  always_ff @(posedge clk_i) closed_o <= coil_i;
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import orl_pkg::*;
;
  logic clk = 0, rst = 1, restart = 0, boot = 0, fault = 0, life, seen;
  logic [255:0] sig = '0;
  orl_relay_cfg_s [7:0] cfg = '0;
  orl_ack_s ack = '0;
  logic [7:0] contact, state, held;
  logic [31:0] rnd = 32'hbe35bd62;
  logic e;
  int errors = 0, n_tests = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  orl_relay_top #(.TICK_CYCLES(4)) u_orl_relay_top (.SYS_CLK_I(clk), .RST_I(rst), .RESTART_I(restart),
    .BOOT_DONE_I(boot), .INT_FAULT_I(fault), .SIGNALS_I(sig), .RELAY_CFG_I(cfg), .ACK_I(ack),
    .CONTACT_O(contact), .RELAY_STATE_O(state), .LATCH_HELD_O(held), .LIFE_CONTACT_O(life));
  orl_switchgear u_orl_switchgear (.clk_i(clk), .coil_i(contact[0]), .closed_o(seen));
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // reference combination of one relay, integer counting
  function automatic logic exp_coll(orl_relay_cfg_s c, logic [255:0] s);
    int hits = 0, n = 0;
    for (int k = 0; k < ORL_NUM_TRIG; k++) if (c.slot[k].assigned) begin
      n++;
      if (s[c.slot[k].sel] ^ c.slot[k].invert) hits++;
    end
    return (n == 0) ? 1'b0 : ((hits > 0) ^ c.relay_invert);
  endfunction
  task automatic chk(string nm, logic ex, logic got);
    n_tests++;
    if (got !== ex) begin
      errors++;
      $display("unexpected %s expected %b seen %b", nm, ex, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    step(7);
    rst = 0;
    step(2);
    chk("life_boot", 1'b0, life);
    boot = 1;
    step(2);
    chk("life_up", 1'b1, life);
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      for (int k = 0; k < 7; k++) begin
        cfg[0].slot[k].assigned = rnd[k] & rnd[k+21];
        cfg[0].slot[k].sel = rnd[k*4 +: 8];
        cfg[0].slot[k].invert = rnd[k+24];
      end
      cfg[0].relay_invert = rnd[31];
      cfg[0].mode = orl_mode_e'(rnd[30]);
      rnd = lfsr(rnd);
      sig = {8{rnd}};
      step(3);
      e = exp_coll(cfg[0], sig);
      chk("state", e, state[0]);
      chk("contact", e ^ cfg[0].mode, contact[0]);
      chk("breaker", e ^ cfg[0].mode, seen);
    end
    cfg[0] = '0;
    sig = '0;
    cfg[0].slot[0].assigned = 1;
    cfg[0].latched = 1;
    sig[0] = 1;
    step(2);
    sig[0] = 0;
    step(2);
    chk("held", 1'b1, held[0]);
    restart = 1;
    step(2);
    chk("life_restart", 1'b0, life);
    restart = 0;
    step(2);
    chk("held_restart", 1'b1, held[0]);
    ack.scada_all = 1;
    ack.all_outputs_ack_signal = 1;
    step(2);
    chk("held_gated", 1'b1, held[0]);
    ack.remote_reset_en = 1;
    step(2);
    chk("held_remote", 1'b0, held[0]);
    ack = '0;
    sig[0] = 1;
    ack.panel = 1;
    step(3);
    chk("held_trig", 1'b1, held[0]);
    sig[0] = 0;
    step(3);
    chk("held_panel", 1'b0, held[0]);
    ack = '0;
    sig[0] = 1;
    cfg[0].ack_assigned = 1;
    cfg[0].ack_sel = 8'h05;
    step(2);
    sig[0] = 0;
    sig[5] = 1;
    step(3);
    chk("held_own", 1'b0, held[0]);
    chk("state_clr", 1'b0, state[0]);
    sig[5] = 0;
    cfg[0].latched = 0;
    cfg[0].hold_ms = 16'h0002;
    sig[0] = 1;
    step(2);
    sig[0] = 0;
    step(8);
    chk("state_hold", 1'b1, state[0]);
    step(8);
    chk("state_rel", 1'b0, state[0]);
    cfg[0].hold_ms = '0;
    cfg[0].latched = 1;
    cfg[0].off_delay_ms = 16'h0002;
    ack.panel = 1;
    sig[0] = 1;
    step(2);
    sig[0] = 0;
    step(9);
    chk("held_delay", 1'b1, held[0]);
    step(8);
    chk("held_delay_end", 1'b0, held[0]);
    fault = 1;
    step(2);
    chk("life_fault", 1'b0, life);
    print_verdict;
  end
endmodule
`default_nettype wire
